// file: dual_port_mii_phy.sv
// phy-side mii for two ports: clocks, nibble paths, status and management
`timescale 1ns/1ps

// What this block does
// - each port makes its own transmit clock: 2.5 or 25 MHz by speed
// - transmit enable, transmit error and the four transmit data lines are sampled at the transmit clock rise
// - transmit error yields h symbols at 100 Mbps only; ignored at 10 Mbps
// - received nibbles are driven on receive data, timed to receive clock
// - receive data valid is high exactly in cycles carrying valid nibbles
// - receive error is raised, on receive clock, for invalid decoded symbols
// - each port makes its own receive clock: 2.5 or 25 MHz by speed
// - collision output stays high for the whole collision, unrelated to mii clocks
// - collision output stays low whenever the port is full duplex
// - half duplex: carrier sense follows transmit or receive activity
// - full duplex: carrier sense follows receive activity only
// - strap high disables management; pins set config bits at reset
// - strap low: pins give reset defaults, then management owns the bits
// - management data is one two-way serial line for both directions
module dual_port_mii_phy #(
  parameter int NUM_PORTS = mii_pkg::NUM_PORTS,
  parameter int FIFO_DEPTH = mii_pkg::FIFO_DEPTH,
  parameter logic [4:0] PHY_ADDR_BASE = mii_pkg::PHY_ADDR_BASE
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic linkClk,
  output logic [NUM_PORTS-1:0] txClk,
  input wire logic [NUM_PORTS-1:0] txEn,
  input wire logic [NUM_PORTS-1:0][mii_pkg::NIB_W-1:0] txData,
  input wire logic [NUM_PORTS-1:0] txEr,
  output logic [NUM_PORTS-1:0] rxClk,
  output logic [NUM_PORTS-1:0] rxDv,
  output logic [NUM_PORTS-1:0][mii_pkg::NIB_W-1:0] rxData,
  output logic [NUM_PORTS-1:0] rxEr,
  output logic [NUM_PORTS-1:0] col,
  output logic [NUM_PORTS-1:0] crs,
  input wire logic [NUM_PORTS-1:0] mdc,
  input wire logic [NUM_PORTS-1:0] mdioIn,
  output logic [NUM_PORTS-1:0] mdioOut,
  output logic [NUM_PORTS-1:0] mdioOe,
  input wire logic [NUM_PORTS-1:0] mgmtPortDisableStrap,
  input wire logic [NUM_PORTS-1:0] cfgSpeed100Pin,
  input wire logic [NUM_PORTS-1:0] cfgFullDuplexPin,
  output logic [NUM_PORTS-1:0][mii_pkg::NIB_W-1:0] lineTxData,
  output logic [NUM_PORTS-1:0] lineTxHSymbol,
  output logic [NUM_PORTS-1:0] lineTxValid,
  input wire logic [NUM_PORTS-1:0] lineTxReady,
  output logic [NUM_PORTS-1:0] lineTxActive,
  input wire logic [NUM_PORTS-1:0][mii_pkg::NIB_W-1:0] lineRxData,
  input wire logic [NUM_PORTS-1:0] lineRxErr,
  input wire logic [NUM_PORTS-1:0] lineRxValid,
  output logic [NUM_PORTS-1:0] lineRxReady,
  input wire logic [NUM_PORTS-1:0] lineRxActive,
  input wire logic [NUM_PORTS-1:0] lineCollision,
  output logic [NUM_PORTS-1:0] speed100,
  output logic [NUM_PORTS-1:0] fullDuplex
);

  // ==========================================================
  // shared helpers

  // reload value of a half-period divider for the selected speed
  function automatic logic [mii_pkg::DIV_W-1:0] halfReload(input logic fast);
    logic [mii_pkg::DIV_W-1:0] v;
    v = fast ? mii_pkg::DIV_W'(mii_pkg::HALF_FAST - 1) : mii_pkg::DIV_W'(mii_pkg::HALF_SLOW - 1);
    return v;
  endfunction

  // control register image for the read path only; reset defaults come from the pins
  function automatic logic [15:0] ctrlImage(input logic fast, input logic full);
    logic [15:0] v;
    v = '0;
    v[mii_pkg::CTRL_SPEED_BIT] = fast;
    v[mii_pkg::CTRL_DUPLEX_BIT] = full;
    return v;
  endfunction

  // ==========================================================
  // link-domain reset: sys_rst carried over by two flops
  logic linkRstMeta_reg, linkRst_reg;

  always_ff @(posedge linkClk) begin
    linkRstMeta_reg <= sys_rst;
    linkRst_reg <= linkRstMeta_reg;
  end

  // ==========================================================
  // per-port logic, one full copy each
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    logic [2:0] pinMeta_reg, pinSync_reg; // strap, speed, duplex pins
    logic mgmtLock_reg, speed_reg, duplex_reg;
    logic txActMeta_reg, txActSync_reg, crs_reg, col_reg;
    logic mgmtWr;
    logic [4:0] mgmtAddr;
    logic [15:0] mgmtWrData, mgmtRdData, statusImage;
    logic speedMeta_reg, speedLink_reg;
    logic [mii_pkg::DIV_W-1:0] txCnt_reg, rxCnt_reg;
    logic txClk_reg, rxClk_reg, txEnLink_reg;
    logic txRise, rxFall;
    logic txWrReady, txWrValid;
    logic [mii_pkg::TX_WORD_W-1:0] txWord, txRdWord;
    logic rxRdValid;
    logic [mii_pkg::RX_WORD_W-1:0] rxRdWord;
    logic [mii_pkg::NIB_W-1:0] rxData_reg;
    logic rxDv_reg, rxEr_reg;

    // ========================================================
    // core domain: straps, configuration, status

    // static pins pass two flops before use
    always_ff @(posedge clk) begin
      pinMeta_reg <= {mgmtPortDisableStrap[p], cfgSpeed100Pin[p], cfgFullDuplexPin[p]};
      pinSync_reg <= pinMeta_reg;
    end

    // strap is caught while reset is held, so hold sys_rst a few cycles
    always_ff @(posedge clk) begin
      if (sys_rst) begin
        mgmtLock_reg <= pinSync_reg[2];
      end
    end

    // pins load the bits at reset in either strap state; writes only if unlocked
    always_ff @(posedge clk) begin
      if (sys_rst) begin
        speed_reg <= pinSync_reg[1];
        duplex_reg <= pinSync_reg[0];
      end else if (mgmtWr && !mgmtLock_reg && mgmtAddr == mii_pkg::REG_CONTROL) begin
        speed_reg <= mgmtWrData[mii_pkg::CTRL_SPEED_BIT];
        duplex_reg <= mgmtWrData[mii_pkg::CTRL_DUPLEX_BIT];
      end
    end

    // status image for management reads
    always_comb begin
      statusImage = '0;
      statusImage[mii_pkg::STAT_RX_ACTIVE_BIT] = lineRxActive[p];
      statusImage[mii_pkg::STAT_TX_ACTIVE_BIT] = txActSync_reg;
      statusImage[mii_pkg::STAT_COLLISION_BIT] = col_reg;
      statusImage[mii_pkg::STAT_MGMT_LOCK_BIT] = mgmtLock_reg;
    end

    // unmapped management addresses read as zero
    always_comb begin
      case (mgmtAddr)
        mii_pkg::REG_CONTROL: mgmtRdData = ctrlImage(speed_reg, duplex_reg);
        mii_pkg::REG_STATUS: mgmtRdData = statusImage;
        default: mgmtRdData = '0;
      endcase
    end

    // management slave, held idle while the strap locks it out
    mii_mdio_slave u_mdio (
      .clk(clk),
      .sys_rst(sys_rst),
      .enable(!mgmtLock_reg),
      .phyAddr(5'(PHY_ADDR_BASE + p)),
      .mdc(mdc[p]),
      .mdioIn(mdioIn[p]),
      .mdioOut(mdioOut[p]),
      .mdioOe(mdioOe[p]),
      .regAddr(mgmtAddr),
      .wrStrobe(mgmtWr),
      .wrData(mgmtWrData),
      .rdData(mgmtRdData)
    );

    // transmit enable comes from the link domain as a level
    always_ff @(posedge clk) begin
      txActMeta_reg <= txEnLink_reg;
      txActSync_reg <= txActMeta_reg;
    end

    // carrier sense and collision; both are free of the mii clocks
    always_ff @(posedge clk) begin
      if (sys_rst) begin
        crs_reg <= 1'b0;
        col_reg <= 1'b0;
      end else begin
        if (duplex_reg) begin
          crs_reg <= lineRxActive[p];
        end else begin
          crs_reg <= lineRxActive[p] || txActSync_reg;
        end
        col_reg <= lineCollision[p] && !duplex_reg;
      end
    end

    assign crs[p] = crs_reg;
    assign col[p] = col_reg;
    assign speed100[p] = speed_reg;
    assign fullDuplex[p] = duplex_reg;
    assign lineTxActive[p] = txActSync_reg;

    // ========================================================
    // link domain: clock generation and nibble timing

    // speed is quasi-static, a level synchroniser is enough
    always_ff @(posedge linkClk) begin
      speedMeta_reg <= speed_reg;
      speedLink_reg <= speedMeta_reg;
    end

    // a rising edge waits for fifo room, which stalls the mac by stretching low
    assign txRise = txCnt_reg == '0 && !txClk_reg && txWrReady;

    always_ff @(posedge linkClk) begin
      if (linkRst_reg) begin
        txCnt_reg <= '0;
        txClk_reg <= 1'b0;
      end else if (txCnt_reg == '0) begin
        if (txClk_reg || txWrReady) begin
          txClk_reg <= !txClk_reg;
          txCnt_reg <= halfReload(speedLink_reg);
        end
      end else begin
        txCnt_reg <= txCnt_reg - 1'b1;
      end
    end

    // receive clock runs free; data changes on its falling edge
    assign rxFall = rxCnt_reg == '0 && rxClk_reg;

    always_ff @(posedge linkClk) begin
      if (linkRst_reg) begin
        rxCnt_reg <= '0;
        rxClk_reg <= 1'b0;
      end else if (rxCnt_reg == '0) begin
        rxClk_reg <= !rxClk_reg;
        rxCnt_reg <= halfReload(speedLink_reg);
      end else begin
        rxCnt_reg <= rxCnt_reg - 1'b1;
      end
    end

    assign txClk[p] = txClk_reg;
    assign rxClk[p] = rxClk_reg;

    // mac inputs change after the previous rise, so they are stable here
    assign txWrValid = txRise && txEn[p];
    assign txWord = {txEr[p] && speedLink_reg, txData[p]};

    always_ff @(posedge linkClk) begin
      if (linkRst_reg) begin
        txEnLink_reg <= 1'b0;
      end else if (txRise) begin
        txEnLink_reg <= txEn[p];
      end
    end

    // transmit nibbles cross to the core on the line side
    mii_async_fifo #(
      .WIDTH(mii_pkg::TX_WORD_W),
      .DEPTH(FIFO_DEPTH)
    ) u_txFifo (
      .wrClk(linkClk),
      .wrRst(linkRst_reg),
      .wrValid(txWrValid),
      .wrReady(txWrReady),
      .wrData(txWord),
      .rdClk(clk),
      .rdRst(sys_rst),
      .rdValid(lineTxValid[p]),
      .rdReady(lineTxReady[p]),
      .rdData(txRdWord)
    );

    assign lineTxData[p] = txRdWord[mii_pkg::NIB_W-1:0];
    assign lineTxHSymbol[p] = txRdWord[mii_pkg::NIB_W];

    // received nibbles cross from the core into the link domain
    mii_async_fifo #(
      .WIDTH(mii_pkg::RX_WORD_W),
      .DEPTH(FIFO_DEPTH)
    ) u_rxFifo (
      .wrClk(clk),
      .wrRst(sys_rst),
      .wrValid(lineRxValid[p]),
      .wrReady(lineRxReady[p]),
      .wrData({lineRxErr[p], lineRxData[p]}),
      .rdClk(linkClk),
      .rdRst(linkRst_reg),
      .rdValid(rxRdValid),
      .rdReady(rxFall),
      .rdData(rxRdWord)
    );

    // one nibble per receive clock; an empty fifo drops data valid
    always_ff @(posedge linkClk) begin
      if (linkRst_reg) begin
        rxData_reg <= '0;
        rxDv_reg <= 1'b0;
        rxEr_reg <= 1'b0;
      end else if (rxFall) begin
        rxDv_reg <= rxRdValid;
        rxData_reg <= rxRdValid ? rxRdWord[mii_pkg::NIB_W-1:0] : '0;
        rxEr_reg <= rxRdValid && rxRdWord[mii_pkg::NIB_W];
      end
    end

    assign rxData[p] = rxData_reg;
    assign rxDv[p] = rxDv_reg;
    assign rxEr[p] = rxEr_reg;
  end

endmodule

// file: mii_pkg.sv
// shared constants for the dual-port mii phy interface
package mii_pkg;

  // ==========================================================
  // port structure
  localparam int NUM_PORTS = 2;
  localparam int NIB_W = 4;
  localparam int TX_WORD_W = NIB_W + 1; // nibble plus h-symbol request
  localparam int RX_WORD_W = NIB_W + 1; // nibble plus decode error
  localparam int FIFO_DEPTH = 8;

  // ==========================================================
  // clock rates and derived divider counts
  localparam int LINK_CLK_KHZ = 50000; // nominal rate of the link reference clock
  localparam int MII_FAST_KHZ = 25000; // mii clock at 100 Mbps
  localparam int MII_SLOW_KHZ = 2500; // mii clock at 10 Mbps
  localparam int HALF_FAST = LINK_CLK_KHZ / (2 * MII_FAST_KHZ);
  localparam int HALF_SLOW = LINK_CLK_KHZ / (2 * MII_SLOW_KHZ);
  localparam int DIV_W = $clog2(HALF_SLOW + 1);

  // ==========================================================
  // management frame layout
  localparam int PREAMBLE_LEN = 32;
  localparam int PRE_W = 6;
  localparam int HDR_BITS = 14;
  localparam int DATA_BITS = 16;
  localparam int CNT_W = 5;
  localparam int READ_FIRST_DRIVE = 1; // fall count at which the phy drives ta zero
  localparam int READ_RELEASE = READ_FIRST_DRIVE + DATA_BITS + 1;
  localparam logic [1:0] MDIO_START = 2'h1;
  localparam logic [1:0] MDIO_OP_READ = 2'h2;
  localparam logic [1:0] MDIO_OP_WRITE = 2'h1;
  localparam logic [4:0] PHY_ADDR_BASE = 5'h00;

  // ==========================================================
  // management registers
  localparam logic [4:0] REG_CONTROL = 5'h00;
  localparam logic [4:0] REG_STATUS = 5'h01;
  localparam int CTRL_SPEED_BIT = 13;
  localparam int CTRL_DUPLEX_BIT = 8;
  localparam int STAT_RX_ACTIVE_BIT = 0;
  localparam int STAT_TX_ACTIVE_BIT = 1;
  localparam int STAT_COLLISION_BIT = 2;
  localparam int STAT_MGMT_LOCK_BIT = 3;

endpackage

// file: mii_async_fifo.sv
// dual-clock fifo with gray-coded pointers
`timescale 1ns/1ps
module mii_async_fifo #(
  parameter int WIDTH = mii_pkg::TX_WORD_W,
  parameter int DEPTH = mii_pkg::FIFO_DEPTH
) (
  input wire logic wrClk,
  input wire logic wrRst,
  input wire logic wrValid,
  output logic wrReady,
  input wire logic [WIDTH-1:0] wrData,
  input wire logic rdClk,
  input wire logic rdRst,
  output logic rdValid,
  input wire logic rdReady,
  output logic [WIDTH-1:0] rdData
);
  // depth must be a power of two, at least four
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wrBin_reg, wrGray_reg, rdBin_reg, rdGray_reg;
  logic [AW:0] rdGrayMeta_reg, rdGraySync_reg, wrGrayMeta_reg, wrGraySync_reg;
  logic [AW:0] wrBin_next, rdBin_next;

  function automatic logic [AW:0] toGray(input logic [AW:0] b);
    return b ^ (b >> 1);
  endfunction

  // ==========================================================
  // write side
  // full when write pointer is a whole lap ahead of the read pointer
  assign wrReady = wrGray_reg != {~rdGraySync_reg[AW:AW-1], rdGraySync_reg[AW-2:0]};
  assign wrBin_next = wrBin_reg + 1'b1;

  always_ff @(posedge wrClk) begin
    if (wrRst) begin
      wrBin_reg <= '0;
      wrGray_reg <= '0;
    end else if (wrValid && wrReady) begin
      wrBin_reg <= wrBin_next;
      wrGray_reg <= toGray(wrBin_next);
    end
  end

  // storage has no reset; only pointers matter
  always_ff @(posedge wrClk) begin
    if (wrValid && wrReady) begin
      mem[wrBin_reg[AW-1:0]] <= wrData;
    end
  end

  // read pointer into the write domain
  always_ff @(posedge wrClk) begin
    rdGrayMeta_reg <= rdGray_reg;
    rdGraySync_reg <= rdGrayMeta_reg;
  end

  // ==========================================================
  // read side
  assign rdValid = rdGray_reg != wrGraySync_reg;
  assign rdData = mem[rdBin_reg[AW-1:0]];
  assign rdBin_next = rdBin_reg + 1'b1;

  always_ff @(posedge rdClk) begin
    if (rdRst) begin
      rdBin_reg <= '0;
      rdGray_reg <= '0;
    end else if (rdValid && rdReady) begin
      rdBin_reg <= rdBin_next;
      rdGray_reg <= toGray(rdBin_next);
    end
  end

  // write pointer into the read domain
  always_ff @(posedge rdClk) begin
    wrGrayMeta_reg <= wrGray_reg;
    wrGraySync_reg <= wrGrayMeta_reg;
  end

endmodule

// file: mii_mdio_slave.sv
// serial management slave, oversampling mdc on the core clock
`timescale 1ns/1ps
module mii_mdio_slave (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic enable,
  input wire logic [4:0] phyAddr,
  input wire logic mdc,
  input wire logic mdioIn,
  output logic mdioOut,
  output logic mdioOe,
  output logic [4:0] regAddr,
  output logic wrStrobe,
  output logic [15:0] wrData,
  input wire logic [15:0] rdData
);
  typedef enum logic [2:0] {M_PRE, M_HDR, M_TA, M_WDATA, M_READ} mdio_state_e;

  mdio_state_e state_reg;
  logic [2:0] mdcSh_reg; // [0] meta, [1] sync, [2] previous
  logic [1:0] dSh_reg; // [0] meta, [1] sync
  logic [mii_pkg::PRE_W-1:0] preCnt_reg;
  logic [mii_pkg::CNT_W-1:0] bitCnt_reg;
  logic [15:0] shift_reg, outShift_reg;
  logic [mii_pkg::HDR_BITS-1:0] hdr;
  logic rise, fall, bitIn;

  // pins pass two flops; edges look only at the second stage on
  always_ff @(posedge clk) begin
    mdcSh_reg <= {mdcSh_reg[1:0], mdc};
    dSh_reg <= {dSh_reg[0], mdioIn};
  end

  assign rise = mdcSh_reg[1] && !mdcSh_reg[2];
  assign fall = !mdcSh_reg[1] && mdcSh_reg[2];
  assign bitIn = dSh_reg[1];
  assign hdr = {shift_reg[mii_pkg::HDR_BITS-2:0], bitIn};

  // frame decoder; a disabled port never leaves preamble hunting
  always_ff @(posedge clk) begin
    wrStrobe <= 1'b0;
    if (sys_rst || !enable) begin
      state_reg <= M_PRE;
      preCnt_reg <= '0;
      bitCnt_reg <= '0;
      shift_reg <= '0;
      outShift_reg <= '0;
      regAddr <= '0;
      wrData <= '0;
      mdioOut <= 1'b0;
      mdioOe <= 1'b0;
    end else begin
      case (state_reg)
        M_PRE: if (rise) begin
          if (bitIn) begin
            if (preCnt_reg < mii_pkg::PREAMBLE_LEN) preCnt_reg <= preCnt_reg + 1'b1;
          end else if (preCnt_reg == mii_pkg::PREAMBLE_LEN) begin
            state_reg <= M_HDR;
            shift_reg <= '0;
            bitCnt_reg <= 5'h01;
          end else begin
            preCnt_reg <= '0;
          end
        end
        M_HDR: if (rise) begin
          shift_reg <= {shift_reg[14:0], bitIn};
          bitCnt_reg <= bitCnt_reg + 1'b1;
          if (bitCnt_reg == mii_pkg::HDR_BITS - 1) begin
            bitCnt_reg <= '0;
            preCnt_reg <= '0;
            regAddr <= hdr[4:0];
            state_reg <= M_PRE;
            if (hdr[13:12] == mii_pkg::MDIO_START && hdr[9:5] == phyAddr) begin
              if (hdr[11:10] == mii_pkg::MDIO_OP_READ) state_reg <= M_READ;
              else if (hdr[11:10] == mii_pkg::MDIO_OP_WRITE) state_reg <= M_TA;
            end
          end
        end
        M_TA: if (rise) begin
          bitCnt_reg <= bitCnt_reg + 1'b1;
          if (bitCnt_reg == 5'h01) begin
            bitCnt_reg <= '0;
            state_reg <= M_WDATA;
          end
        end
        M_WDATA: if (rise) begin
          shift_reg <= {shift_reg[14:0], bitIn};
          bitCnt_reg <= bitCnt_reg + 1'b1;
          if (bitCnt_reg == mii_pkg::DATA_BITS - 1) begin
            wrData <= {shift_reg[14:0], bitIn};
            wrStrobe <= 1'b1;
            state_reg <= M_PRE;
          end
        end
        M_READ: if (fall) begin
          bitCnt_reg <= bitCnt_reg + 1'b1;
          if (bitCnt_reg == mii_pkg::READ_FIRST_DRIVE) begin
            mdioOe <= 1'b1;
            mdioOut <= 1'b0;
            outShift_reg <= rdData;
          end else if (bitCnt_reg == mii_pkg::READ_RELEASE) begin
            mdioOe <= 1'b0;
            state_reg <= M_PRE;
          end else if (bitCnt_reg > mii_pkg::READ_FIRST_DRIVE) begin
            mdioOut <= outShift_reg[15];
            outShift_reg <= {outShift_reg[14:0], 1'b0};
          end
        end
        default: state_reg <= M_PRE;
      endcase
    end
  end

endmodule

// file: mii_phy_monitor.sv
// port-level checker for the dual-port mii phy
`timescale 1ns/1ps
module mii_phy_monitor #(
  parameter int NUM_PORTS = 2
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic linkClk,
  input wire logic [NUM_PORTS-1:0] rxDv,
  input wire logic [NUM_PORTS-1:0] rxEr,
  input wire logic [NUM_PORTS-1:0] col,
  input wire logic [NUM_PORTS-1:0] crs,
  input wire logic [NUM_PORTS-1:0] mdioOe,
  input wire logic [NUM_PORTS-1:0] mgmtPortDisableStrap,
  input wire logic [NUM_PORTS-1:0] lineTxHSymbol,
  input wire logic [NUM_PORTS-1:0] lineTxValid,
  input wire logic [NUM_PORTS-1:0] lineTxActive,
  input wire logic [NUM_PORTS-1:0] lineRxActive,
  input wire logic [NUM_PORTS-1:0] lineCollision,
  input wire logic [NUM_PORTS-1:0] speed100,
  input wire logic [NUM_PORTS-1:0] fullDuplex
);
  // ==========================================================
  // status outputs, one clk of latency by design choice
  col_follow_a: assert property (@(posedge clk) disable iff (sys_rst)
    lineCollision[0] && !fullDuplex[0] |=> col[0]) else $error("collision not shown");
  col_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
    $fell(col[0]) |-> $past(!lineCollision[0] || fullDuplex[0])) else $error("col dropped early");
  col_fdx_a: assert property (@(posedge clk) disable iff (sys_rst)
    fullDuplex[0] && $past(fullDuplex[0]) |-> !col[0]) else $error("col in full duplex");
  crs_rx_a: assert property (@(posedge clk) disable iff (sys_rst)
    lineRxActive[0] || lineTxActive[0] && !fullDuplex[0] |=> crs[0]) else $error("crs missed");
  crs_fdx_a: assert property (@(posedge clk) disable iff (sys_rst)
    fullDuplex[0] && $past(fullDuplex[0] && !lineRxActive[0]) |-> !crs[0])
    else $error("crs without receive in full duplex");
  mgmt_lock_a: assert property (@(posedge clk) disable iff (sys_rst)
    mgmtPortDisableStrap[1] |-> !mdioOe[1]) else $error("locked port drove mdio");
  h_slow_a: assert property (@(posedge clk) disable iff (sys_rst)
    lineTxValid[0] && !speed100[0] |-> !lineTxHSymbol[0]) else $error("h symbol at 10M");
  // ==========================================================
  // link side outputs
  rx_err_dv_a: assert property (@(posedge linkClk) disable iff (sys_rst)
    rxEr[0] |-> rxDv[0]) else $error("rxEr without rxDv");
endmodule
bind dual_port_mii_phy mii_phy_monitor #(.NUM_PORTS(NUM_PORTS)) mon (.clk(clk),
  .sys_rst(sys_rst), .linkClk(linkClk), .rxDv(rxDv), .rxEr(rxEr), .col(col), .crs(crs),
  .mdioOe(mdioOe), .mgmtPortDisableStrap(mgmtPortDisableStrap), .lineTxValid(lineTxValid),
  .lineTxHSymbol(lineTxHSymbol), .lineRxActive(lineRxActive), .lineCollision(lineCollision),
  .speed100(speed100), .fullDuplex(fullDuplex), .lineTxActive(lineTxActive));

// file: mac_model.sv
// mac model driving transmit nibbles on the phy transmit clock
`timescale 1ns/1ps
module mac_model (
  input wire logic txClk,
  output logic txEn,
  output logic [3:0] txData,
  output logic txEr
);
  logic [4:0] pend[$]; // {error, nibble} words still to send
  initial begin
    txEn = 1'b0;
    txData = 4'h5;
    txEr = 1'b0;
  end
  // change on the fall so the phy's rising sample sees settled lines
  always @(negedge txClk) begin
    if (pend.size() > 0) begin
      {txEr, txData} <= pend.pop_front();
      txEn <= 1'b1;
    end else begin
      txEn <= 1'b0;
      txEr <= 1'b0;
      txData <= ~txData; // idle lines carry junk, never a stale copy
    end
  end
endmodule

// file: testbench.sv
// self-checking bench for the dual-port mii phy
`timescale 1ns/1ps
module testbench;
  // ==========================================================
  // signals
  logic clk, sys_rst, linkClk, expSpd;
  logic [1:0] rxClk, txClk, rxDv, rxEr, col, crs, mdc, mdioOut, mdioOe, staDrv, strap, spdPin;
  logic [1:0] fdxPin, lineTxHSymbol, lineTxValid, lineTxReady, lineTxActive, lineRxErr;
  logic [1:0] lineRxValid, lineRxReady, lineRxActive, lineCollision, speed100, fullDuplex;
  logic [1:0][3:0] rxData, lineTxData, lineRxData;
  wire [1:0] txEn, txEr, mdioIn;
  wire [1:0][3:0] txData;
  logic [4:0] txExp[$], rxExp[$];
  logic [31:0] seed = 32'd42436;
  logic [31:0] rb;
  logic [15:0] v;
  int errors = 0, total_checks = 0;
  // wire level: phy when enabled, else station or pull-up
  assign mdioIn = (mdioOe & mdioOut) | (~mdioOe & staDrv);
  dual_port_mii_phy dut (.clk(clk), .sys_rst(sys_rst), .linkClk(linkClk), .txClk(txClk),
    .txEn(txEn), .txData(txData), .txEr(txEr), .rxClk(rxClk), .rxDv(rxDv), .rxData(rxData),
    .rxEr(rxEr), .col(col), .crs(crs), .mdc(mdc), .mdioIn(mdioIn), .mdioOut(mdioOut),
    .mdioOe(mdioOe), .mgmtPortDisableStrap(strap), .cfgSpeed100Pin(spdPin),
    .cfgFullDuplexPin(fdxPin), .lineTxData(lineTxData), .lineTxHSymbol(lineTxHSymbol),
    .lineTxValid(lineTxValid), .lineTxReady(lineTxReady), .lineTxActive(lineTxActive),
    .lineRxData(lineRxData), .lineRxErr(lineRxErr), .lineRxValid(lineRxValid),
    .lineRxReady(lineRxReady), .lineRxActive(lineRxActive), .lineCollision(lineCollision),
    .speed100(speed100), .fullDuplex(fullDuplex));
  mac_model mac0 (.txClk(txClk[0]), .txEn(txEn[0]), .txData(txData[0]), .txEr(txEr[0]));
  mac_model mac1 (.txClk(txClk[1]), .txEn(txEn[1]), .txData(txData[1]), .txEr(txEr[1]));
  // ==========================================================
  // clocks: link clock in its own unrelated phase
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    linkClk = 1'b0;
    #7;
    forever #24 linkClk = ~linkClk;
  end
  // ==========================================================
  // helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [15:0] pop(ref logic [4:0] q[$]);
    return q.size() > 0 ? {11'h0, q.pop_front()} : 16'hffff; // spurious output never matches
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks=%0d errors=%0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic per(ref logic [1:0] c, input int p, input int e);
    time t0;
    @(posedge c[p]);
    t0 = $time;
    @(posedge c[p]);
    chk(16'($time - t0), 16'(e));
  endtask
  task automatic tx_burst(input int n);
    logic [4:0] w;
    for (int i = 0; i < n; i++) begin
      w = 5'(rnd());
      mac0.pend.push_back(w);
      txExp.push_back({w[4] & expSpd, w[3:0]});
    end
  endtask
  // data held until the edge at which ready is high
  task automatic rx_burst(input int n);
    logic [4:0] w;
    @(posedge clk);
    #1;
    lineRxActive[0] = 1'b1;
    for (int i = 0; i < n; i++) begin
      w = 5'(rnd());
      {lineRxErr[0], lineRxData[0]} = w;
      lineRxValid[0] = 1'b1;
      while (lineRxReady[0] !== 1'b1) begin
        @(posedge clk);
        #1;
      end
      rxExp.push_back(w);
      @(posedge clk);
      #1;
    end
    lineRxValid[0] = 1'b0;
    lineRxActive[0] = 1'b0;
  endtask
  task automatic drain();
    for (int i = 0; i < 3000 && txExp.size() + rxExp.size() > 0; i++) @(posedge clk);
    chk(16'(txExp.size() + rxExp.size()), 16'h0);
  endtask
  // management frame, 8 clk per bit keeps mdc far below its limit
  task automatic mgmt(input int p, input logic [1:0] op, input logic [4:0] ra,
      input logic [15:0] wd);
    logic [63:0] f;
    f = {32'hffffffff, mii_pkg::MDIO_START, op, mii_pkg::PHY_ADDR_BASE + 5'(p), ra, 2'h2, wd};
    for (int i = 0; i < 65; i++) begin
      mdc[p] = 1'b0;
      staDrv[p] = (i < 46 || (op == mii_pkg::MDIO_OP_WRITE && i < 64)) ? f[63-i] : 1'b1;
      repeat (4) @(posedge clk);
      #1;
      if (i >= 48 && i < 64) v = {v[14:0], mdioIn[p]};
      mdc[p] = 1'b1;
      repeat (4) @(posedge clk);
      #1;
    end
  endtask
  // ==========================================================
  // far-side stalls and random collisions
  always @(posedge clk) begin
    #1;
    rb = rnd();
    lineTxReady = {1'b1, rb[0] & rb[1]};
    lineCollision = {1'b0, rb[2] & rb[3] & rb[4]};
  end
  // result watchers take the oldest note on each output
  always @(posedge clk) begin
    if (sys_rst === 1'b0 && lineTxValid[0] === 1'b1 && lineTxReady[0] === 1'b1)
      chk({11'h0, lineTxHSymbol[0], lineTxData[0]}, pop(txExp));
  end
  always @(posedge rxClk[0]) begin
    if (rxDv[0] === 1'b1) chk({11'h0, rxEr[0], rxData[0]}, pop(rxExp));
  end
  initial begin
    #(50 * 40000);
    errors++;
    print_verdict();
  end
  // ==========================================================
  // main sequence
  initial begin
    sys_rst = 1'b1;
    {mdc, staDrv, strap, spdPin, fdxPin} = 10'b00_11_10_01_10;
    {lineTxReady, lineCollision, lineRxErr, lineRxValid, lineRxActive} = 10'h300;
    lineRxData = 8'h00;
    expSpd = 1'b1;
    repeat (6) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    repeat (10) @(posedge clk);
    chk({12'h0, speed100, fullDuplex}, {12'h0, spdPin, fdxPin});
    per(rxClk, 0, 2 * mii_pkg::HALF_FAST * 48);
    per(rxClk, 1, 2 * mii_pkg::HALF_SLOW * 48);
    per(txClk, 0, 2 * mii_pkg::HALF_FAST * 48);
    tx_burst(20);
    rx_burst(24);
    drain();
    mgmt(0, mii_pkg::MDIO_OP_READ, mii_pkg::REG_CONTROL, 16'h0);
    chk(v & 16'h2100, 16'h2000);
    lineRxActive[0] = 1'b1;
    mgmt(0, mii_pkg::MDIO_OP_READ, mii_pkg::REG_STATUS, 16'h0);
    lineRxActive[0] = 1'b0;
    chk(v & 16'h0009, 16'h0001);
    mgmt(1, mii_pkg::MDIO_OP_READ, mii_pkg::REG_CONTROL, 16'h0);
    chk(v, 16'hffff);
    mgmt(0, mii_pkg::MDIO_OP_WRITE, mii_pkg::REG_CONTROL, 16'h0100);
    repeat (50) @(posedge clk);
    expSpd = 1'b0;
    chk({14'h0, speed100[0], fullDuplex[0]}, 16'h0001);
    per(txClk, 0, 2 * mii_pkg::HALF_SLOW * 48);
    tx_burst(8);
    rx_burst(12);
    drain();
    print_verdict();
  end
endmodule
